// ==== pkg/anp_defines.svh ====
// Constants for the negotiation page and status register bank
// ==========================================================================
// What this block does
// - Partner speed and duplex abilities read-only
// - Partner selector field, resets to one
// - Parallel detection fault latched high
// - Partner next page ability shown
// - Local next page ability reads one
// - New page received latched high
// - Partner negotiation ability shown
// - Software writes more-pages bit per page
// - Message page bit writable, resets one
// - Comply-with-message bit writable, resets zero
// - Transmit toggle mirrors previous code word
// - Eleven-bit message field writable, resets one
// - Partner next page fields captured read-only
// - Partner acknowledge bit shown read-only
// - Partner able-to-act bit shown read-only
// - Partner toggle shown read-only
// - Symbol error frame counter clears on read
// - Jabber interrupt enable, resets off
// - Receive error interrupt enable, resets off
// - Jabber and receive error flags clear on read
`ifndef ANP_DEFINES_SVH
`define ANP_DEFINES_SVH
// ==========================================================================
// Register addresses
`define ANP_REG_ABILITY 5'h05
`define ANP_REG_EXPANSION 5'h06
`define ANP_REG_LOCAL_NP 5'h07
`define ANP_REG_PARTNER_NP 5'h08
`define ANP_REG_ERR_COUNT 5'h15
`define ANP_REG_INT 5'h1B
// ==========================================================================
// Field positions
`define ANP_ABL_MSB 9
`define ANP_ABL_LSB 5
`define ANP_SEL_MSB 4
`define ANP_EXP_PD_FAULT 4
`define ANP_EXP_LP_NP 3
`define ANP_EXP_NP_ABLE 2
`define ANP_EXP_PAGE_RCVD 1
`define ANP_EXP_LP_AN 0
`define ANP_NP_MORE 15
`define ANP_NP_MSG_PAGE 13
`define ANP_NP_ACK2 12
`define ANP_NP_TOGGLE 11
`define ANP_NP_MSG_MSB 10
`define ANP_INT_EN_JAB 15
`define ANP_INT_EN_RXE 14
`define ANP_INT_JAB 7
`define ANP_INT_RXE 6
// ==========================================================================
// Reset values and counter limits
`define ANP_SEL_RST 5'h01
`define ANP_MSG_PAGE_RST 1'h1
`define ANP_MSG_RST 11'h001
`define ANP_CNT_RST 16'h0000
`define ANP_CNT_MAX 16'hFFFF
`define ANP_CNT_ONE 16'h0001
`define ANP_WORD_ZERO 16'h0000
// ==========================================================================
// Serial management frame
`define ANP_PRE_LEN 6'h20
`define ANP_HDR_LAST 5'h0B
`define ANP_TA_LAST 5'h01
`define ANP_DATA_LAST 5'h0F
`define ANP_OP_RD 2'h2
`define ANP_OP_WR 2'h1
`define ANP_PIN_W 7
`endif

// ==== pkg/anp_pkg.sv ====
// Types shared by the negotiation register bank
package anp_pkg;
  // Frame receiver states, Gray along the frame path
  typedef enum logic [2:0] {
    ANP_PRE = 3'h0,
    ANP_START = 3'h1,
    ANP_HDR = 3'h3,
    ANP_TA = 3'h2,
    ANP_DATA = 3'h6
  } anp_mdio_state_e;
  // One management register word
  typedef logic [15:0] anp_word_t;
endpackage

// ==== pkg/anp_mgmt_if.sv ====
// Register access carrier between frame receiver and register bank
interface anp_mgmt_if;
  logic rd_req;             // One-cycle read strobe
  logic wr_req;             // One-cycle write strobe
  logic [4:0] addr;         // Register address
  anp_pkg::anp_word_t wdata; // Write data
  anp_pkg::anp_word_t rdata; // Read data, valid cycle after rd_req
  modport slave (output rd_req, output wr_req, output addr, output wdata, input rdata);
  modport bank (input rd_req, input wr_req, input addr, input wdata, output rdata);
endinterface

// ==== rtl/anp_pin_sync.sv ====
// Two-stage synchroniser for the management pins
`include "anp_defines.svh"
module anp_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins in, synchronised out
  input wire logic [`ANP_PIN_W-1:0] pin_in,
  output logic [`ANP_PIN_W-1:0] pin_sync
);
  // First stage, read only by the second
  logic [`ANP_PIN_W-1:0] meta;

  // ==========================================================================
  // Two flops per pin
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      meta <= pin_in;
      pin_sync <= meta;
    end
  end
endmodule

// ==== rtl/anp_mdio_slave.sv ====
// Serial management frame receiver and read data shifter
`include "anp_defines.svh"
module anp_mdio_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Synchronised pins
  input wire logic mdc_s,
  input wire logic mdio_s,
  input wire logic [4:0] phy_addr_s,
  // Data pin drive
  output logic mdio_out,
  output logic mdio_oe,
  // Register access
  anp_mgmt_if.slave mif
);
  anp_pkg::anp_mdio_state_e state; // Frame position
  logic mdc_d;                     // Delayed clock for edge find
  logic rise;                      // Management clock rising edge
  logic [5:0] pre_cnt;             // Preamble ones seen
  logic [4:0] bit_cnt;             // Bit within field
  logic [11:0] hdr;                // Op, address, register
  logic [11:0] next_hdr;           // Header including this bit
  logic hdr_end;                   // Last header bit now
  logic addr_ok;                   // Frame is for us
  logic is_rd;                     // Current frame reads
  logic [15:0] rx_sh;              // Write data being shifted in
  logic [15:0] tx_sh;              // Read data being shifted out

  assign rise = mdc_s & ~mdc_d;
  assign next_hdr = {hdr[10:0], mdio_s};
  assign hdr_end = rise && (state == anp_pkg::ANP_HDR) && (bit_cnt == `ANP_HDR_LAST);
  assign addr_ok = (next_hdr[9:5] == phy_addr_s);

  // ==========================================================================
  // Edge finder
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      mdc_d <= 1'h0;
    else
      mdc_d <= mdc_s;
  end

  // ==========================================================================
  // Frame state; a sampled clock at 25 MHz limits the management clock rate
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= anp_pkg::ANP_PRE;
      pre_cnt <= '0;
      bit_cnt <= '0;
      hdr <= '0;
      is_rd <= 1'h0;
      rx_sh <= '0;
    end
    else if (rise)
    begin
      unique case (state)
        anp_pkg::ANP_PRE:
        begin
          // Count ones, a zero after enough of them starts a frame
          if (mdio_s)
            pre_cnt <= (pre_cnt == `ANP_PRE_LEN) ? pre_cnt : pre_cnt + 6'h01;
          else
          begin
            if (pre_cnt == `ANP_PRE_LEN)
              state <= anp_pkg::ANP_START;
            pre_cnt <= '0;
          end
        end
        anp_pkg::ANP_START:
        begin
          state <= mdio_s ? anp_pkg::ANP_HDR : anp_pkg::ANP_PRE;
          bit_cnt <= '0;
        end
        anp_pkg::ANP_HDR:
        begin
          hdr <= next_hdr;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `ANP_HDR_LAST)
          begin
            bit_cnt <= '0;
            is_rd <= (next_hdr[11:10] == `ANP_OP_RD);
            // Foreign address or bad opcode: let the frame pass by
            if (addr_ok && (next_hdr[11:10] == `ANP_OP_RD || next_hdr[11:10] == `ANP_OP_WR))
              state <= anp_pkg::ANP_TA;
            else
              state <= anp_pkg::ANP_PRE;
          end
        end
        anp_pkg::ANP_TA:
        begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `ANP_TA_LAST)
          begin
            bit_cnt <= '0;
            state <= anp_pkg::ANP_DATA;
          end
        end
        anp_pkg::ANP_DATA:
        begin
          rx_sh <= {rx_sh[14:0], mdio_s};
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `ANP_DATA_LAST)
            state <= anp_pkg::ANP_PRE;
        end
        default:
          state <= anp_pkg::ANP_PRE;
      endcase
    end
  end

  // ==========================================================================
  // Access strobes towards the register bank
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mif.rd_req <= 1'h0;
      mif.wr_req <= 1'h0;
      mif.addr <= '0;
      mif.wdata <= '0;
    end
    else
    begin
      mif.rd_req <= hdr_end && addr_ok && (next_hdr[11:10] == `ANP_OP_RD);
      mif.wr_req <= rise && (state == anp_pkg::ANP_DATA) && (bit_cnt == `ANP_DATA_LAST) && !is_rd;
      if (hdr_end)
        mif.addr <= next_hdr[4:0];
      if (rise && (state == anp_pkg::ANP_DATA) && (bit_cnt == `ANP_DATA_LAST))
        mif.wdata <= {rx_sh[14:0], mdio_s};
    end
  end

  // ==========================================================================
  // Read drive: zero in second turnaround bit, then data MSB first
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mdio_oe <= 1'h0;
      mdio_out <= 1'h0;
      tx_sh <= '0;
    end
    else if (rise && is_rd)
    begin
      if (state == anp_pkg::ANP_TA && bit_cnt == 5'h00)
      begin
        mdio_oe <= 1'h1;
        mdio_out <= 1'h0;
      end
      else if (state == anp_pkg::ANP_TA)
      begin
        mdio_out <= mif.rdata[15];
        tx_sh <= {mif.rdata[14:0], 1'h0};
      end
      else if (state == anp_pkg::ANP_DATA && bit_cnt == `ANP_DATA_LAST)
        mdio_oe <= 1'h0;
      else if (state == anp_pkg::ANP_DATA)
      begin
        mdio_out <= tx_sh[15];
        tx_sh <= {tx_sh[14:0], 1'h0};
      end
    end
  end
endmodule

// ==== rtl/anp_regs.sv ====
// Negotiation page, expansion, error count and interrupt register bank
`include "anp_defines.svh"
module anp_regs (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Serial management pins
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  input wire logic [4:0] PHY_ADDR,
  // Negotiation engine, partner base page
  input wire logic [4:0] LP_ABILITY,
  input wire logic [4:0] LP_SELECTOR,
  input wire logic LP_NP_ABLE,
  input wire logic LP_AN_ABLE,
  input wire logic PD_FAULT,
  // Negotiation engine, next page exchange
  input wire logic PAGE_RCVD,
  input wire logic [15:0] RX_NP_WORD,
  input wire logic TX_TOGGLE,
  // Receiver events
  input wire logic RECEIVE_SYMBOL_ERROR,
  input wire logic JABBER,
  input wire logic RX_ERR_EVENT,
  // Local next page towards the engine
  output logic NP_MORE,
  output logic NP_MSG_PAGE,
  output logic NP_ACK2,
  output logic [10:0] NP_MESSAGE,
  // Interrupt
  output logic INTR
);
  logic [`ANP_PIN_W-1:0] pins_s;   // Synchronised pins
  logic [4:0] lp_ability;          // T4, 100 FD, 100 HD, 10 FD, 10 HD
  logic [4:0] lp_selector;         // Partner selector
  logic lp_np_able;                // Partner next page capable
  logic lp_an_able;                // Partner negotiation capable
  logic pd_fault_flag;             // Latched parallel detect fault
  logic page_rcvd_flag;            // Latched page received
  logic np_toggle;                 // Toggle of previous sent word
  anp_pkg::anp_word_t partner_np;  // Captured partner next page
  anp_pkg::anp_word_t err_count;   // Symbol error frames
  logic int_en_jab;                // Jabber interrupt enable
  logic int_en_rxe;                // Receive error interrupt enable
  logic jab_flag;                  // Jabber occurred
  logic rxe_flag;                  // Receive error occurred
  logic rd_exp;                    // Expansion read this cycle
  logic rd_cnt;                    // Counter read this cycle
  logic rd_int;                    // Interrupt register read
  logic wr_np;                     // Local next page write
  logic wr_int;                    // Interrupt register write
  logic next_pd_fault;
  logic next_page_rcvd;
  logic next_jab;
  logic next_rxe;
  logic next_en_jab;
  logic next_en_rxe;
  anp_pkg::anp_word_t next_err_count;

  anp_mgmt_if mif();

  // Address match for one access strobe
  function automatic logic reg_hit(input logic req, input logic [4:0] a, input logic [4:0] r);
    return req && (a == r);
  endfunction

  // Counter step that sticks at full scale rather than wrapping
  function automatic anp_pkg::anp_word_t sat_inc(input anp_pkg::anp_word_t v);
    return (v == `ANP_CNT_MAX) ? v : v + `ANP_CNT_ONE;
  endfunction

  // ==========================================================================
  // Pin synchroniser and frame receiver
  anp_pin_sync u_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .pin_in({MDC, MDIO_IN, PHY_ADDR}),
    .pin_sync(pins_s)
  );

  anp_mdio_slave u_mdio (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .mdc_s(pins_s[6]),
    .mdio_s(pins_s[5]),
    .phy_addr_s(pins_s[4:0]),
    .mdio_out(MDIO_OUT),
    .mdio_oe(MDIO_OE),
    .mif(mif)
  );

  // Access decode
  assign rd_exp = reg_hit(mif.rd_req, mif.addr, `ANP_REG_EXPANSION);
  assign rd_cnt = reg_hit(mif.rd_req, mif.addr, `ANP_REG_ERR_COUNT);
  assign rd_int = reg_hit(mif.rd_req, mif.addr, `ANP_REG_INT);
  assign wr_np = reg_hit(mif.wr_req, mif.addr, `ANP_REG_LOCAL_NP);
  assign wr_int = reg_hit(mif.wr_req, mif.addr, `ANP_REG_INT);

  // ==========================================================================
  // Partner base page, followed every cycle from the engine
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      lp_ability <= '0;
      lp_selector <= `ANP_SEL_RST;
      lp_np_able <= 1'h0;
      lp_an_able <= 1'h0;
    end
    else
    begin
      lp_ability <= LP_ABILITY;
      lp_selector <= LP_SELECTOR;
      lp_np_able <= LP_NP_ABLE;
      lp_an_able <= LP_AN_ABLE;
    end
  end

  // ==========================================================================
  // Next values of flags; an event in the reading cycle survives the read
  always_comb
  begin
    next_pd_fault = PD_FAULT | (pd_fault_flag & ~rd_exp);
    next_page_rcvd = PAGE_RCVD | (page_rcvd_flag & ~rd_exp);
    next_jab = JABBER | (jab_flag & ~rd_int);
    next_rxe = RX_ERR_EVENT | (rxe_flag & ~rd_int);
    next_en_jab = wr_int ? mif.wdata[`ANP_INT_EN_JAB] : int_en_jab;
    next_en_rxe = wr_int ? mif.wdata[`ANP_INT_EN_RXE] : int_en_rxe;
    // Counter: a read clears it, a frame in the same cycle counts as one
    if (RECEIVE_SYMBOL_ERROR)
      next_err_count = rd_cnt ? `ANP_CNT_ONE : sat_inc(err_count);
    else
      next_err_count = rd_cnt ? `ANP_CNT_RST : err_count;
  end

  // ==========================================================================
  // Latched expansion flags
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      pd_fault_flag <= 1'h0;
      page_rcvd_flag <= 1'h0;
    end
    else
    begin
      pd_fault_flag <= next_pd_fault;
      page_rcvd_flag <= next_page_rcvd;
    end
  end

  // ==========================================================================
  // Local next page, written by software, toggle from the engine
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      NP_MORE <= 1'h0;
      NP_MSG_PAGE <= `ANP_MSG_PAGE_RST;
      NP_ACK2 <= 1'h0;
      NP_MESSAGE <= `ANP_MSG_RST;
      np_toggle <= 1'h0;
    end
    else
    begin
      np_toggle <= TX_TOGGLE;
      if (wr_np)
      begin
        NP_MORE <= mif.wdata[`ANP_NP_MORE];
        NP_MSG_PAGE <= mif.wdata[`ANP_NP_MSG_PAGE];
        NP_ACK2 <= mif.wdata[`ANP_NP_ACK2];
        NP_MESSAGE <= mif.wdata[`ANP_NP_MSG_MSB:0];
      end
    end
  end

  // ==========================================================================
  // Partner next page, captured whole when a page arrives
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      partner_np <= `ANP_WORD_ZERO;
    else if (PAGE_RCVD)
      partner_np <= RX_NP_WORD;
  end

  // ==========================================================================
  // Error counter and interrupt register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      err_count <= `ANP_CNT_RST;
      int_en_jab <= 1'h0;
      int_en_rxe <= 1'h0;
      jab_flag <= 1'h0;
      rxe_flag <= 1'h0;
      INTR <= 1'h0;
    end
    else
    begin
      err_count <= next_err_count;
      int_en_jab <= next_en_jab;
      int_en_rxe <= next_en_rxe;
      jab_flag <= next_jab;
      rxe_flag <= next_rxe;
      // Built from next values so the pin tracks the flags without lag
      INTR <= (next_jab & next_en_jab) | (next_rxe & next_en_rxe);
    end
  end

  // ==========================================================================
  // Read data, captured on the read strobe before any clear lands
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      mif.rdata <= `ANP_WORD_ZERO;
    else if (mif.rd_req)
    begin
      mif.rdata <= `ANP_WORD_ZERO;
      case (mif.addr)
        `ANP_REG_ABILITY:
        begin
          mif.rdata[`ANP_ABL_MSB:`ANP_ABL_LSB] <= lp_ability;
          mif.rdata[`ANP_SEL_MSB:0] <= lp_selector;
        end
        `ANP_REG_EXPANSION:
        begin
          mif.rdata[`ANP_EXP_PD_FAULT] <= pd_fault_flag;
          mif.rdata[`ANP_EXP_LP_NP] <= lp_np_able;
          mif.rdata[`ANP_EXP_NP_ABLE] <= 1'h1;
          mif.rdata[`ANP_EXP_PAGE_RCVD] <= page_rcvd_flag;
          mif.rdata[`ANP_EXP_LP_AN] <= lp_an_able;
        end
        `ANP_REG_LOCAL_NP:
        begin
          mif.rdata[`ANP_NP_MORE] <= NP_MORE;
          mif.rdata[`ANP_NP_MSG_PAGE] <= NP_MSG_PAGE;
          mif.rdata[`ANP_NP_ACK2] <= NP_ACK2;
          mif.rdata[`ANP_NP_TOGGLE] <= np_toggle;
          mif.rdata[`ANP_NP_MSG_MSB:0] <= NP_MESSAGE;
        end
        `ANP_REG_PARTNER_NP:
          mif.rdata <= partner_np;
        `ANP_REG_ERR_COUNT:
          mif.rdata <= err_count;
        `ANP_REG_INT:
        begin
          mif.rdata[`ANP_INT_EN_JAB] <= int_en_jab;
          mif.rdata[`ANP_INT_EN_RXE] <= int_en_rxe;
          mif.rdata[`ANP_INT_JAB] <= jab_flag;
          mif.rdata[`ANP_INT_RXE] <= rxe_flag;
        end
        // Unmapped addresses read as zero
        default:
          mif.rdata <= `ANP_WORD_ZERO;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_rd_exp;
    mif.rd_req && (mif.addr == `ANP_REG_EXPANSION);
  endsequence

  sequence s_rd_cnt;
    mif.rd_req && (mif.addr == `ANP_REG_ERR_COUNT);
  endsequence

  property p_ability_read;
    mif.rd_req && (mif.addr == `ANP_REG_ABILITY) |=>
      mif.rdata[`ANP_ABL_MSB:`ANP_ABL_LSB] == $past(lp_ability) &&
      mif.rdata[15:10] == 6'h00;
  endproperty
  a_ability_read: assert property (p_ability_read) else $error("ability readback wrong");

  property p_pd_hold;
    pd_fault_flag && !rd_exp |=> pd_fault_flag;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("fault flag dropped unread");

  property p_pd_clear;
    s_rd_exp ##0 !PD_FAULT ##0 pd_fault_flag |=> !pd_fault_flag ##0 (mif.rdata[`ANP_EXP_PD_FAULT]);
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("fault flag read clear wrong");

  property p_np_able;
    s_rd_exp |=> mif.rdata[`ANP_EXP_NP_ABLE];
  endproperty
  a_np_able: assert property (p_np_able) else $error("local next page ability not one");

  property p_page_set;
    PAGE_RCVD |=> page_rcvd_flag && partner_np == $past(RX_NP_WORD);
  endproperty
  a_page_set: assert property (p_page_set) else $error("page receipt not captured");

  property p_np_write;
    wr_np |=> NP_MORE == $past(mif.wdata[`ANP_NP_MORE]) &&
      NP_MESSAGE == $past(mif.wdata[`ANP_NP_MSG_MSB:0]);
  endproperty
  a_np_write: assert property (p_np_write) else $error("next page write lost");

  property p_cnt_inc;
    RECEIVE_SYMBOL_ERROR && !rd_cnt && err_count != `ANP_CNT_MAX |=>
      err_count == $past(err_count) + `ANP_CNT_ONE;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("error count did not step");

  property p_cnt_clr;
    s_rd_cnt ##0 !RECEIVE_SYMBOL_ERROR |=> err_count == `ANP_CNT_RST ##1 1'h1;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("error count not cleared");

  property p_jab_set;
    JABBER |=> jab_flag [*1] ##0 (INTR == int_en_jab || rxe_flag);
  endproperty
  a_jab_set: assert property (p_jab_set) else $error("jabber flag not set");

  property p_intr;
    INTR == ((jab_flag & int_en_jab) | (rxe_flag & int_en_rxe));
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt pin mismatch");
endmodule

// ==== tb/anp_smi_model.sv ====
// Station management controller model driving MDC and MDIO frames
module anp_smi_model (
  // Core clock
  input wire logic clk,
  // Management pins
  output logic mdc,
  output logic mdio,
  input wire logic dut_out,
  input wire logic dut_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_out = 1'b1; // Master data
  logic m_oe = 1'b0; // Master drive enable
  int half = 3; // MDC half period in clocks; 3 keeps samples clear of reply lag
  initial mdc = 1'b0;
  // ====
  // Shared line; pull-up wins when nobody drives
  assign mdio = dut_oe ? dut_out : (m_oe ? m_out : 1'b1);
  // One MDC period, data changed while MDC is low, sampled just before it rises
  task automatic bit_io(input logic b, input logic drv, output logic s);
    @(posedge clk) mdc <= 1'b0;
    m_out <= b;
    m_oe <= drv;
    repeat (half - 1) @(posedge clk);
    @(negedge clk) s = mdio;
    @(posedge clk) mdc <= 1'b1;
    repeat (half - 1) @(posedge clk);
  endtask
  // Whole frame; any opcode but write releases the line after the header
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] tail;
    logic s;
    hdr = {2'b01, op, pa, ra};
    tail = {2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
    for (int i = 17; i >= 0; i--)
    begin
      bit_io(tail[i], op == 2'b01, s);
      rd = {rd[14:0], s};
    end
    // MDC parks low between frames
    @(posedge clk) mdc <= 1'b0;
    m_oe <= 1'b0;
    repeat (half) @(posedge clk);
  endtask
endmodule

// ==== tb/test_autoneg_page_status_regs.sv ====
// Self-checking bench for the negotiation page and status register bank
module test_autoneg_page_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Clock, reset and pins
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic mdc, mdio, mdio_out, mdio_oe, intr, np_more, np_msg_page, np_ack2;
  logic [10:0] np_message;
  logic [4:0] phy_addr = 5'h00, lp_ability = 5'h00, lp_selector = 5'h01;
  logic lp_np_able = 1'b0, lp_an_able = 1'b0, tx_toggle = 1'b0;
  logic [4:0] ev = 5'h00; // Fault, page, symbol error, jabber, receive error
  logic [15:0] rx_np_word = 16'h0000, rd, w, n;
  int err_total = 0, num_checks = 0, cycles = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  anp_smi_model smi (.clk(CORE_CLK), .mdc(mdc), .mdio(mdio), .dut_out(mdio_out),
    .dut_oe(mdio_oe));
  anp_regs dut_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .MDC(mdc), .MDIO_IN(mdio),
    .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe), .PHY_ADDR(phy_addr), .LP_ABILITY(lp_ability),
    .LP_SELECTOR(lp_selector), .LP_NP_ABLE(lp_np_able), .LP_AN_ABLE(lp_an_able),
    .PD_FAULT(ev[4]), .PAGE_RCVD(ev[3]), .RX_NP_WORD(rx_np_word), .TX_TOGGLE(tx_toggle),
    .RECEIVE_SYMBOL_ERROR(ev[2]), .JABBER(ev[1]), .RX_ERR_EVENT(ev[0]), .NP_MORE(np_more),
    .NP_MSG_PAGE(np_msg_page), .NP_ACK2(np_ack2), .NP_MESSAGE(np_message), .INTR(intr));
  // ====
  // Compare, count and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    smi.frame(2'b10, phy_addr, ra, 16'h0000, rd);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    smi.frame(2'b01, phy_addr, ra, d, rd);
  endtask
  // One-cycle engine events
  task automatic pulse(input logic [4:0] m);
    @(posedge CORE_CLK) ev <= m;
    @(posedge CORE_CLK) ev <= 5'h00;
  endtask
  // Local page readback: toggle comes from the engine, bit 14 reads 0
  function automatic logic [15:0] np_exp(input logic [15:0] d, input logic t);
    return {d[15], 1'b0, d[13:12], t, d[10:0]};
  endfunction
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, about three to four and a half times the expected run, depending on the MDC rate picked
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      stop_test();
    end
  end
  // ====
  // Main sequence
  initial
  begin
    w = 16'($urandom(32'hCEF12FE0));
    phy_addr <= 5'($urandom);
    repeat (8) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    rd_chk(5'h07, 16'h2001);
    chk({2'b00, np_more, np_msg_page, np_ack2, np_message}, 16'h1001);
    rd_chk(5'h06, 16'h0004);
    rd_chk(5'h08, 16'h0000);
    rd_chk(5'h15, 16'h0000);
    rd_chk(5'h1B, 16'h0000);
    // Partner ability follows the engine, slow or fast master picked at random per read
    repeat (3)
    begin
      lp_ability <= 5'($urandom);
      lp_selector <= 5'($urandom);
      smi.half = 3 + 2 * int'($urandom % 2);
      @(posedge CORE_CLK);
      rd_chk(5'h05, {6'h00, lp_ability, lp_selector});
    end
    // Local next page write and readback
    repeat (4)
    begin
      w = 16'($urandom);
      tx_toggle <= 1'($urandom);
      wr(5'h07, w);
      rd_chk(5'h07, np_exp(w, tx_toggle));
      chk({2'b00, np_more, np_msg_page, np_ack2, np_message},
        {2'b00, w[15], w[13:12], w[10:0]});
    end
    // Latched flags and captured partner page
    lp_np_able <= 1'b1;
    lp_an_able <= 1'b1;
    rx_np_word <= 16'($urandom);
    pulse(5'h18);
    rd_chk(5'h06, 16'h001F);
    wr(5'h06, 16'h0000);
    rd_chk(5'h06, 16'h000D);
    rd_chk(5'h08, rx_np_word);
    // Errored frame counter
    n = 16'(1 + $urandom % 20);
    repeat (n) pulse(5'h04);
    rd_chk(5'h15, n);
    rd_chk(5'h15, 16'h0000);
    // Enables, flags and interrupt output
    wr(5'h1B, 16'hC0C0);
    rd_chk(5'h1B, 16'hC000);
    pulse(5'h02);
    @(negedge CORE_CLK) chk({15'h0000, intr}, 16'h0001);
    rd_chk(5'h1B, 16'hC080);
    rd_chk(5'h1B, 16'hC000);
    chk({15'h0000, intr}, 16'h0000);
    wr(5'h1B, 16'h8000);
    pulse(5'h01);
    @(negedge CORE_CLK) chk({15'h0000, intr}, 16'h0000);
    rd_chk(5'h1B, 16'h8040);
    // Frames for another station, bad opcode, unmapped address
    smi.frame(2'b01, phy_addr ^ 5'h01, 5'h07, 16'h0000, rd);
    smi.frame(2'b10, phy_addr ^ 5'h01, 5'h07, 16'h0000, rd);
    chk(rd, 16'hFFFF);
    smi.frame(2'b11, phy_addr, 5'h07, 16'h0000, rd);
    chk(rd, 16'hFFFF);
    smi.frame(2'b00, phy_addr, 5'h07, 16'h0000, rd);
    chk(rd, 16'hFFFF);
    rd_chk(5'h07, np_exp(w, tx_toggle));
    rd_chk(5'h10, 16'h0000);
    stop_test();
  end
endmodule
